// [design/dpa_arbiter_cfg.sv]
// dual-port clock arbiter and configuration byte slave
// Overview of operation
// [RQ1] watch both port clock lines all the time to decide the owning port
// [RQ2] with both ports idle the arbiter is inactive and drives no clock line
// [RQ3] a START on one port pulls the other port's clock line low
// [RQ4] release the held clock once the initiator's clock stayed high one second
// [RQ5] the held-off master waits while stretched, then does its transfers
// [RQ6] byte layout: bit3 write enable, bits2-1 active bank, bit0 bank count
// [RQ7] bank count 0 gives two host banks, 1 gives only the lower bank
// [RQ8] host memory writes accepted only while the write-enable bit is 1
// [RQ9] write enable gates host writes only, never display writes
// [RQ10] display port writes are always allowed
// [RQ11] two banks and override bit 0: bank select pin picks lower or upper
// [RQ12] two banks and override bit 1: choice bit picks bank, pin ignored
// [RQ13] configuration byte kept in non-volatile storage across power loss
// [RQ14] both ports reach the byte, write at address 62h, read at 63h
// [RQ15] read: START, 63h, ack, one data byte, master no-ack then STOP
// [RQ16] write: START, 62h, dummy, data, STOP, each of three bytes acked
// [RQ17] dummy byte value and upper four data bits are disregarded
`timescale 1ns/1ps
`default_nettype none

module dpa_arbiter_cfg
	import dpa_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = DPA_HOLD_CYCLES
) (
	// clock and reset
	input  wire logic            ref_clk,
	input  wire logic            rstn,
	// display port pins
	input  wire dpa_pin_in_type  dsp_pin_in,
	output var  dpa_pin_out_type dsp_pin_out,
	// host port pins
	input  wire dpa_pin_in_type  host_pin_in,
	output var  dpa_pin_out_type host_pin_out,
	// bank select pin
	input  wire logic            bank_select_input,
	// non-volatile store of the configuration byte
	input  wire logic [3:0]      nv_restore_value,
	output logic                 nv_store_stb,
	output logic [3:0]           nv_store_value,
	// memory-map controls
	output logic                 host_bank_upper,
	output logic                 host_single_bank,
	output logic                 host_write_allow,
	output logic                 display_write_allow,
	output logic [1:0]           port_owner
);

	localparam int HCW = $clog2(HOLD_CYCLES + 1);
	localparam logic [HCW-1:0] HOLD_LAST = HCW'(HOLD_CYCLES - 1);

	logic [1:0] scl_s1_r, scl_s2_r, scl_d_r;
	logic [1:0] sda_s1_r, sda_s2_r, sda_d_r;
	logic       sel_s1_r, sel_s2_r;
	logic [1:0] scl_rise, scl_fall, start_det, stop_det, hold;

	// two-stage synchronisers plus one delay stage for edge finding
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			scl_s1_r <= 2'h3;
			scl_s2_r <= 2'h3;
			scl_d_r  <= 2'h3;
			sda_s1_r <= 2'h3;
			sda_s2_r <= 2'h3;
			sda_d_r  <= 2'h3;
			sel_s1_r <= 1'b0;
			sel_s2_r <= 1'b0;
		end else begin
			scl_s1_r <= {host_pin_in.scl, dsp_pin_in.scl};
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= {host_pin_in.sda, dsp_pin_in.sda};
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
			sel_s1_r <= bank_select_input;
			sel_s2_r <= sel_s1_r;
		end
	end

	// bus events of both ports
	assign scl_rise  = scl_s2_r & ~scl_d_r;
	assign scl_fall  = ~scl_s2_r & scl_d_r;
	assign start_det = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r; // RQ1
	assign stop_det  = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;

	dpa_arb_type    arb_r, arb_nxt;
	logic [HCW-1:0] hcnt_r, hcnt_nxt;
	logic           own_idx;

	// arbiter: owner taken on START, freed after the owner clock stays high
	always_comb begin
		arb_nxt  = arb_r;
		hcnt_nxt = hcnt_r;
		own_idx  = (arb_r == ARB_HOST);
		case (arb_r)
			ARB_IDLE: begin
				hcnt_nxt = '0;
				if (start_det[PORT_DSP]) begin
					arb_nxt = ARB_DSP; // RQ3
				end else if (start_det[PORT_HOST]) begin
					arb_nxt = ARB_HOST; // RQ3
				end
			end
			ARB_DSP, ARB_HOST: begin
				if (!scl_s2_r[own_idx]) begin
					hcnt_nxt = '0; // RQ4
				end else if (hcnt_r == HOLD_LAST) begin
					hcnt_nxt = '0;
					arb_nxt  = ARB_IDLE; // RQ4
				end else begin
					hcnt_nxt = hcnt_r + 1'b1;
				end
			end
			default: begin
				arb_nxt  = ARB_IDLE;
				hcnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			arb_r  <= ARB_IDLE;
			hcnt_r <= '0;
		end else begin
			arb_r  <= arb_nxt;
			hcnt_r <= hcnt_nxt;
		end
	end

	// the non-owning port has its clock stretched low
	assign hold[PORT_DSP]  = (arb_r == ARB_HOST); // RQ3 RQ2
	assign hold[PORT_HOST] = (arb_r == ARB_DSP);  // RQ3 RQ2

	logic [CFG_W-1:0] cfg_r, cfg_nxt;
	dpa_slv_type      st_r [2];
	logic [3:0]       cnt_r [2];
	logic [7:0]       sh_r [2];
	logic [1:0]       drv_r;
	logic [1:0]       commit;

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			dpa_slv_type st_nxt;
			logic [3:0]  cnt_nxt;
			logic [7:0]  sh_nxt;
			logic        drv_nxt;

			// configuration byte slave of one port
			always_comb begin
				st_nxt    = st_r[p];
				cnt_nxt   = cnt_r[p];
				sh_nxt    = sh_r[p];
				drv_nxt   = drv_r[p];
				commit[p] = 1'b0;
				if (start_det[p]) begin
					st_nxt  = SLV_DEV;
					cnt_nxt = 4'h0;
					drv_nxt = 1'b0;
				end else if (stop_det[p]) begin
					st_nxt  = SLV_IDLE;
					drv_nxt = 1'b0;
				end else begin
					case (st_r[p])
						SLV_IDLE: begin
							drv_nxt = 1'b0;
						end
						SLV_DEV, SLV_DUMMY, SLV_DATA: begin
							if (scl_rise[p]) begin
								sh_nxt  = {sh_r[p][6:0], sda_s2_r[p]};
								cnt_nxt = cnt_r[p] + 4'h1;
							end else if (scl_fall[p] && cnt_r[p] == BITS_PER_BYTE) begin
								cnt_nxt = 4'h0;
								drv_nxt = 1'b1; // RQ16
								if (st_r[p] == SLV_DUMMY) begin
									st_nxt = SLV_DUMMY_ACK; // RQ17
								end else if (st_r[p] == SLV_DATA) begin
									st_nxt    = SLV_DATA_ACK;
									commit[p] = 1'b1; // RQ16
								end else if (sh_r[p] == CFG_ADDR_WR || sh_r[p] == CFG_ADDR_RD) begin
									st_nxt = SLV_DEV_ACK; // RQ14
								end else begin
									st_nxt  = SLV_IDLE;
									drv_nxt = 1'b0;
								end
							end
						end
						SLV_DEV_ACK: begin
							if (scl_fall[p]) begin
								if (sh_r[p][0]) begin
									st_nxt  = SLV_READ; // RQ15
									sh_nxt  = {{(8-CFG_W){1'b0}}, cfg_r} << 1;
									drv_nxt = 1'b1; // bit 7 always reads as zero
									cnt_nxt = 4'h1;
								end else begin
									st_nxt  = SLV_DUMMY;
									drv_nxt = 1'b0;
								end
							end
						end
						SLV_DUMMY_ACK: begin
							if (scl_fall[p]) begin
								st_nxt  = SLV_DATA;
								drv_nxt = 1'b0;
							end
						end
						SLV_DATA_ACK: begin
							if (scl_fall[p]) begin
								st_nxt  = SLV_IDLE; // further bytes are not acked
								drv_nxt = 1'b0;
							end
						end
						SLV_READ: begin
							if (scl_fall[p]) begin
								if (cnt_r[p] == BITS_PER_BYTE) begin
									st_nxt  = SLV_READ_ACK; // RQ15
									drv_nxt = 1'b0;
								end else begin
									drv_nxt = ~sh_r[p][7];
									sh_nxt  = {sh_r[p][6:0], 1'b0};
									cnt_nxt = cnt_r[p] + 4'h1;
								end
							end
						end
						SLV_READ_ACK: begin
							if (scl_rise[p]) begin
								st_nxt = SLV_IDLE; // RQ15
							end
						end
						default: begin
							st_nxt  = SLV_IDLE;
							drv_nxt = 1'b0;
						end
					endcase
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					st_r[p]  <= SLV_IDLE;
					cnt_r[p] <= 4'h0;
					sh_r[p]  <= 8'h00;
					drv_r[p] <= 1'b0;
				end else begin
					st_r[p]  <= st_nxt;
					cnt_r[p] <= cnt_nxt;
					sh_r[p]  <= sh_nxt;
					drv_r[p] <= drv_nxt;
				end
			end

			// an address byte of 62h is acked on the following low phase
			addr_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ14
				(st_r[p] == SLV_DEV && scl_fall[p] && cnt_r[p] == 4'h8 && sh_r[p] == 8'h62
				 && !start_det[p] && !stop_det[p]) |=> (drv_r[p] && st_r[p] == SLV_DEV_ACK))
				else $error("config write address not acknowledged");
			// a read releases data after the eighth bit for the master no-ack
			read_release_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ15
				(st_r[p] == SLV_READ_ACK) |-> !drv_r[p])
				else $error("data line driven during master acknowledge");
		end
	endgenerate

	logic loaded_r, loaded_nxt, store_nxt, store_r;
	logic bank_upper_nxt, bank_upper_r;

	// configuration byte: restored from the store, written from either port
	always_comb begin
		cfg_nxt    = cfg_r;
		loaded_nxt = 1'b1;
		store_nxt  = 1'b0;
		if (!loaded_r) begin
			cfg_nxt = nv_restore_value; // RQ13
		end else if (commit[PORT_DSP]) begin
			cfg_nxt   = sh_r[PORT_DSP][CFG_W-1:0]; // RQ17 RQ6
			store_nxt = 1'b1; // RQ13
		end else if (commit[PORT_HOST]) begin
			cfg_nxt   = sh_r[PORT_HOST][CFG_W-1:0]; // RQ17 RQ6
			store_nxt = 1'b1;
		end
		if (cfg_r[CFG_COUNT_BIT]) begin
			bank_upper_nxt = 1'b0; // RQ7
		end else if (cfg_r[CFG_OVERRIDE_BIT]) begin
			bank_upper_nxt = cfg_r[CFG_CHOICE_BIT]; // RQ12
		end else begin
			bank_upper_nxt = sel_s2_r; // RQ11
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cfg_r        <= CFG_RESET;
			loaded_r     <= 1'b0;
			store_r      <= 1'b0;
			bank_upper_r <= 1'b0;
		end else begin
			cfg_r        <= cfg_nxt;
			loaded_r     <= loaded_nxt;
			store_r      <= store_nxt;
			bank_upper_r <= bank_upper_nxt;
		end
	end

	// outputs
	assign host_bank_upper     = bank_upper_r;
	assign host_single_bank    = cfg_r[CFG_COUNT_BIT]; // RQ7
	assign host_write_allow    = cfg_r[CFG_WE_BIT]; // RQ8 RQ9
	assign display_write_allow = 1'b1; // RQ10
	assign nv_store_stb        = store_r;
	assign nv_store_value      = cfg_r;
	assign port_owner          = arb_r;
	assign dsp_pin_out  = '{scl_o: 1'b0, scl_oe: hold[PORT_DSP], sda_o: 1'b0, sda_oe: drv_r[PORT_DSP]};
	assign host_pin_out = '{scl_o: 1'b0, scl_oe: hold[PORT_HOST], sda_o: 1'b0, sda_oe: drv_r[PORT_HOST]};

	// checks on arbitration and configuration
	idle_no_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ2
		(arb_r == ARB_IDLE) |-> (!dsp_pin_out.scl_oe && !host_pin_out.scl_oe))
		else $error("clock line driven while arbiter idle");
	start_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ3
		(arb_r == ARB_IDLE && start_det[PORT_DSP]) |=> (host_pin_out.scl_oe && !dsp_pin_out.scl_oe))
		else $error("host clock not held after display start");
	release_time_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ4
		$fell(host_pin_out.scl_oe) |-> ($past(hcnt_r) == HOLD_LAST && $past(scl_s2_r[PORT_DSP])))
		else $error("held clock released before one second high");
	release_due_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ4
		(arb_r == ARB_HOST && scl_s2_r[PORT_HOST] && hcnt_r == HOLD_LAST) |=> (arb_r == ARB_IDLE))
		else $error("held clock not released when due");
	single_bank_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ7
		$past(cfg_r[CFG_COUNT_BIT]) |-> !host_bank_upper)
		else $error("upper bank chosen in single bank mode");
	override_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ12
		($past(!cfg_r[CFG_COUNT_BIT] && cfg_r[CFG_OVERRIDE_BIT])) |-> (host_bank_upper == $past(cfg_r[CFG_CHOICE_BIT])))
		else $error("bank override not applied");
	pin_bank_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ11
		($past(!cfg_r[CFG_COUNT_BIT] && !cfg_r[CFG_OVERRIDE_BIT])) |-> (host_bank_upper == $past(sel_s2_r)))
		else $error("bank select pin not followed");
	host_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ8
		(host_write_allow == cfg_r[CFG_WE_BIT]) && display_write_allow)
		else $error("write gating wrong");
	cfg_write_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ16
		(loaded_r && commit[PORT_HOST] && !commit[PORT_DSP])
		|=> (cfg_r == $past(sh_r[PORT_HOST][3:0]) && nv_store_stb))
		else $error("configuration write not stored");

	cov_dsp_own_c: cover property (@(posedge ref_clk) disable iff (!rstn) arb_r == ARB_DSP ##1 arb_r == ARB_IDLE);
	cov_host_write_c: cover property (@(posedge ref_clk) disable iff (!rstn) commit[PORT_HOST]);
	cov_dsp_read_c: cover property (@(posedge ref_clk) disable iff (!rstn) st_r[PORT_DSP] == SLV_READ_ACK);

endmodule

`default_nettype wire

// [design/dpa_pkg.sv]
// constants, pin carriers and state encodings of the dual-port arbiter
package dpa_pkg;

	// pin groups of one two-wire port
	typedef struct packed {
		logic scl;
		logic sda;
	} dpa_pin_in_type;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} dpa_pin_out_type;

	// arbiter ownership states
	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_DSP  = 2'b01,
		ARB_HOST = 2'b10
	} dpa_arb_type;

	// configuration-byte serial slave states
	typedef enum logic [3:0] {
		SLV_IDLE      = 4'b0000,
		SLV_DEV       = 4'b0001,
		SLV_DEV_ACK   = 4'b0010,
		SLV_DUMMY     = 4'b0011,
		SLV_DUMMY_ACK = 4'b0100,
		SLV_DATA      = 4'b0101,
		SLV_DATA_ACK  = 4'b0110,
		SLV_READ      = 4'b0111,
		SLV_READ_ACK  = 4'b1000
	} dpa_slv_type;

	// port indices
	localparam int PORT_DSP  = 0;
	localparam int PORT_HOST = 1;

	// device address bytes of the configuration byte
	localparam logic [7:0] CFG_ADDR_WR = 8'h62;
	localparam logic [7:0] CFG_ADDR_RD = 8'h63;

	// configuration byte field positions
	localparam int CFG_WE_BIT = 3;
	localparam int CFG_OVERRIDE_BIT = 2;
	localparam int CFG_CHOICE_BIT = 1;
	localparam int CFG_COUNT_BIT = 0;
	localparam int CFG_W = 4;
	localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;

	// serial framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// hold-off release time
	localparam longint unsigned CLK_PERIOD_PS = 4000;
	localparam longint unsigned HOLD_TIME_S = 1;
	localparam int unsigned DPA_HOLD_CYCLES = 32'((HOLD_TIME_S * 64'd1000000000000) / CLK_PERIOD_PS);

endpackage

// [verification/dpa_i2c_master.sv]
// open-drain two-wire master standing in for the display controller or the host
`timescale 1ns/1ps
`default_nettype none

module dpa_i2c_master (
	// bench clock and resolved wire levels
	input  wire logic clk,
	input  wire logic scl_w,
	input  wire logic sda_w,
	// pulls on the wires, high while pulling low
	output logic      scl_lo,
	output logic      sda_lo
);
	initial begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end

	// wait while the clock wire is held low by the device, bounded
	task automatic wait_hi();
		int n;
		n = 0;
		while (scl_w !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
	endtask

	// start only once the own clock has been let go
	task automatic start();
		wait_hi();
		repeat (8) @(posedge clk);
		sda_lo <= 1'b1;
		repeat (8) @(posedge clk);
		scl_lo <= 1'b1;
	endtask

	// one bit of sixteen clocks (64 ns): data set while low, sampled at the end of high
	task automatic bit_io(input logic b, output logic r);
		repeat (2) @(posedge clk);
		sda_lo <= !b;
		repeat (6) @(posedge clk);
		scl_lo <= 1'b0;
		@(posedge clk);
		wait_hi();
		repeat (7) @(posedge clk);
		r = sda_w;
		scl_lo <= 1'b1;
	endtask

	// msb-first byte plus the ninth bit; mb is what the master puts there
	task automatic byte_io(input logic [7:0] d, input logic mb, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(mb, r);
		ack = !r;
	endtask

	// data rises while the clock is high
	task automatic stop();
		repeat (2) @(posedge clk);
		sda_lo <= 1'b1;
		repeat (6) @(posedge clk);
		scl_lo <= 1'b0;
		repeat (8) @(posedge clk);
		sda_lo <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// [verification/dual_port_arbiter_bank_config_tb.sv]
// self-checking bench of the dual-port arbiter and configuration byte
`timescale 1ns/1ps
`default_nettype none

module dual_port_arbiter_bank_config_tb;
	import dpa_pkg::*;
	localparam int unsigned HOLD = 64;

	logic            ref_clk = 1'b0;
	logic            rstn = 1'b0;
	logic            sel = 1'b0;
	logic [3:0]      nv = 4'ha;
	dpa_pin_out_type d_o;
	dpa_pin_out_type h_o;
	dpa_pin_in_type  d_i;
	dpa_pin_in_type  h_i;
	logic            d_scl_lo, d_sda_lo, h_scl_lo, h_sda_lo;
	logic            stb, upper, single, wal, dwal;
	logic [3:0]      sval;
	logic [1:0]      owner;
	logic [7:0]      q;
	logic            a;
	int              error_cnt = 0;
	int              n_checks = 0;
	int              stb_cnt = 0;
	int              cyc = 0;
	logic [7:0]      tdat [6] = '{8'ha0, 8'h50, 8'h0c, 8'hf6, 8'h0f, 8'h09};
	logic            tpin [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
	logic            tup [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

	// wires with pull-ups: low while any party pulls
	assign d_i = {!(d_scl_lo | d_o.scl_oe), !(d_sda_lo | d_o.sda_oe)};
	assign h_i = {!(h_scl_lo | h_o.scl_oe), !(h_sda_lo | h_o.sda_oe)};

	always #2 ref_clk = !ref_clk;

	dpa_arbiter_cfg #(.HOLD_CYCLES(HOLD)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .dsp_pin_in(d_i), .dsp_pin_out(d_o),
		.host_pin_in(h_i), .host_pin_out(h_o), .bank_select_input(sel),
		.nv_restore_value(nv), .nv_store_stb(stb), .nv_store_value(sval),
		.host_bank_upper(upper), .host_single_bank(single), .host_write_allow(wal),
		.display_write_allow(dwal), .port_owner(owner)
	);

	dpa_i2c_master m_dsp (.clk(ref_clk), .scl_w(d_i.scl), .sda_w(d_i.sda), .scl_lo(d_scl_lo), .sda_lo(d_sda_lo));
	dpa_i2c_master m_host (.clk(ref_clk), .scl_w(h_i.scl), .sda_w(h_i.sda), .scl_lo(h_scl_lo), .sda_lo(h_sda_lo));

	// count commit strobes of the store
	always @(posedge ref_clk) begin
		if (stb === 1'b1) stb_cnt++;
	end

	// cut a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic results();
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// bus steps on the display port (hp 0) or the host port (hp 1)
	task automatic m_start(input logic hp);
		if (hp) m_host.start();
		else m_dsp.start();
	endtask

	task automatic m_byte(input logic hp, input logic [7:0] d, input logic mb, output logic [7:0] r, output logic k);
		if (hp) m_host.byte_io(d, mb, r, k);
		else m_dsp.byte_io(d, mb, r, k);
	endtask

	task automatic m_stop(input logic hp);
		if (hp) m_host.stop();
		else m_dsp.stop();
	endtask

	// configuration write from either port, every byte acknowledged
	task automatic cfg_wr(input logic hp, input logic [7:0] dummy, input logic [7:0] data);
		logic [7:0] r;
		logic       k;
		m_start(hp);
		m_byte(hp, CFG_ADDR_WR, 1'b1, r, k);
		chk(8'(k), 8'h01);
		m_byte(hp, dummy, 1'b1, r, k);
		chk(8'(k), 8'h01);
		m_byte(hp, data, 1'b1, r, k);
		chk(8'(k), 8'h01);
		m_stop(hp);
	endtask

	// configuration read from either port, ended with no-ack
	task automatic cfg_rd(input logic hp, output logic [7:0] v);
		logic [7:0] r;
		logic       k;
		m_start(hp);
		m_byte(hp, CFG_ADDR_RD, 1'b1, r, k);
		chk(8'(k), 8'h01);
		m_byte(hp, 8'hff, 1'b1, v, k);
		m_stop(hp);
	endtask

	initial begin
		logic [7:0] v;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge ref_clk);
		// idle after reset, stored byte restored
		chk(8'(owner), 8'h00);
		chk(8'({d_o.scl_oe, h_o.scl_oe}), 8'h00);
		chk(8'({wal, single, upper}), 8'h04);
		// display start holds the host clock, released after the hold time
		m_dsp.start();
		repeat (6) @(posedge ref_clk);
		chk(8'({owner, h_o.scl_oe, d_o.scl_oe}), 8'h06);
		m_dsp.byte_io(8'h60, 1'b1, q, a);
		chk(8'(a), 8'h00);
		m_dsp.stop();
		repeat (HOLD - 24) @(posedge ref_clk);
		chk(8'({owner, h_o.scl_oe}), 8'h03);
		repeat (24) @(posedge ref_clk);
		chk(8'({owner, h_o.scl_oe}), 8'h00);
		chk(8'(stb_cnt), 8'h00);
		// host read arrives mid-write and is stretched until release
		fork
			cfg_wr(1'b0, 8'h3c, 8'h08);
			begin
				repeat (40) @(posedge ref_clk);
				cfg_rd(1'b1, v);
			end
		join
		chk(v, 8'h08);
		// bank selection, write enable and bank count over a table; writer and reader ports alternate
		for (int i = 0; i < 6; i++) begin
			sel <= tpin[i];
			cfg_wr(i[0], ~tdat[i], tdat[i]);
			cfg_rd(!i[0], v);
			chk(v, {4'h0, tdat[i][3:0]});
			chk(8'(upper), 8'(tup[i]));
			chk(8'({wal, single}), 8'({tdat[i][CFG_WE_BIT], tdat[i][CFG_COUNT_BIT]}));
			chk(8'(dwal), 8'h01);
			chk(8'(sval), 8'(tdat[i][3:0]));
			chk(8'(stb_cnt), 8'(i + 2));
		end
		results();
	end
endmodule

`default_nettype wire
